// ==== rtl/debug_halt_pkg.sv ====
//----------------------------------------------------------------------
// Shared constants for the debug halt and bus gating block
//----------------------------------------------------------------------
package debug_halt_pkg;

  // Register offsets, byte addresses on APB
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SIZE = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_TRIG = 12'h00C;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_REPEAT_BIT = 1;
  localparam int CTRL_BURST_BIT = 2;
  localparam int CTRL_START_BIT = 3;

  // Trigger enable register fields
  localparam int TRIG_PUSH_BIT = 0;
  localparam int TRIG_REGW_BIT = 1;

  // Status register fields
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_BUSY_BIT = 16;
  localparam int ST_DMA_REQ_BIT = 17;
  localparam int ST_DMA_IDLE_BIT = 18;
  localparam int ST_PENDING_BIT = 19;
  localparam int ST_HALTED_BIT = 20;
  localparam int ST_BP_HIT_BIT = 21;

  // Reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Burst-block interleave: slots per period, slots owned by the DMA
  localparam logic [3:0] BURST_PERIOD = 4'hA;
  localparam logic [3:0] BURST_DMA_SLOTS = 4'h8;

  // Quiet cycles after the last DMA request before the bus counts as free
  localparam logic [1:0] IDLE_GAP = 2'h3;

  // Addressing modes of a stack-push fetch
  typedef enum logic [1:0] {am_register, am_indexed, am_indirect, am_immediate} addr_mode_e;

  // Operation that produced a register write
  typedef enum logic [2:0] {
    op_plain,
    op_rotate_right_unsigned_multi,
    op_rotate_right_carry_multi,
    op_rotate_right_arith_multi,
    op_rotate_left_arith_multi
  } regw_op_e;

  // Register writes from repeated rotates never raise the write trigger
  function automatic logic is_rotate_multi(input logic [2:0] op);
    is_rotate_multi = (op == op_rotate_right_unsigned_multi) || (op == op_rotate_right_carry_multi) ||
                      (op == op_rotate_right_arith_multi) || (op == op_rotate_left_arith_multi);
  endfunction

endpackage

// ==== rtl/dma_ctl_if.sv ====
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Control and status between the gating logic and the DMA engine
//----------------------------------------------------------------------
interface dma_ctl_if #(parameter int SIZE_W = 16);
  logic enable;
  logic repeat_mode;
  logic burst_mode;
  logic start;
  logic freeze;
  logic [SIZE_W-1:0] size;
  logic [SIZE_W-1:0] count;
  logic busy;
  logic bus_req;
  logic xfer;

  modport engine(input enable, repeat_mode, burst_mode, start, freeze, size, output count, busy, bus_req, xfer);
  modport ctrl(output enable, repeat_mode, burst_mode, start, freeze, size, input count, busy, bus_req, xfer);
endinterface

// ==== rtl/dma_engine.sv ====
`timescale 1ns/1ps
//----------------------------------------------------------------------
// DMA channel engine: block and burst-block, single or repeated
//----------------------------------------------------------------------
module dma_engine #(
  parameter int SIZE_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  dma_ctl_if.engine dma
);

  logic [SIZE_W-1:0] count_reg;
  logic [SIZE_W-1:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic [3:0] slot_reg;
  logic [3:0] slot_next;
  wire logic dma_slot;
  wire logic last_xfer;
  wire logic kick;

  // Slot decode: DMA owns the first slots of each burst period
  assign dma_slot = !dma.burst_mode || (slot_reg < debug_halt_pkg::BURST_DMA_SLOTS);
  assign dma.bus_req = busy_reg && dma_slot && !dma.freeze;
  assign dma.xfer = dma.bus_req;
  assign last_xfer = dma.xfer && (count_reg == SIZE_W'(1));
  assign kick = dma.start && dma.enable && !busy_reg && (dma.size != '0);
  assign dma.count = count_reg;
  assign dma.busy = busy_reg;

  // Next counter, busy and slot values
  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    slot_next = slot_reg;
    if (kick) begin
      count_next = dma.size;
      busy_next = 1'b1;
      slot_next = '0;
    end else if (last_xfer) begin
      if (dma.repeat_mode && dma.enable) begin
        count_next = dma.size;
      end else begin
        busy_next = 1'b0;
      end
    end else if (dma.xfer) begin
      count_next = count_reg - SIZE_W'(1);
    end
    if (busy_reg && dma.burst_mode && !dma.freeze && !kick) begin
      slot_next = (slot_reg == debug_halt_pkg::BURST_PERIOD - 4'h1) ? 4'h0 : slot_reg + 4'h1;
    end
  end

  // State registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      slot_reg <= '0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      slot_reg <= slot_next;
    end
  end

endmodule // dma_engine

// ==== rtl/debug_halt_bus_gating.sv ====
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
// Operation
// - In repeated mode a finished transfer reloads the size counter and restarts at once unless enable was cleared.
// - In burst-block mode the DMA owns eight of every ten cycles and the CPU the other two.
// - A debug halt is granted only when the DMA has been quiet for three cycles and the CPU is not requesting the bus.
// - A combined push fetch and pushed value trigger is missed for push modes other than register or immediate.
// - A conditional register-write trigger gives no breakpoint when the write comes from a repeated rotate.
module debug_halt_bus_gating #(
  parameter int SIZE_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_bus_req,
  input wire logic halt_req_pin,
  input wire logic push_fetch,
  input wire logic [1:0] push_mode,
  input wire logic push_value_match,
  input wire logic regw_valid,
  input wire logic [2:0] regw_op,
  input wire logic regw_match,
  output logic dma_bus_req,
  output logic dma_xfer,
  output logic halt_pending,
  output logic device_halt
);

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {st_run, st_pending, st_halted} halt_state_e;

  dma_ctl_if #(.SIZE_W(SIZE_W)) dma ();

  logic [2:0] ctrl_reg;
  logic [2:0] ctrl_next;
  logic [SIZE_W-1:0] size_reg;
  logic [1:0] trig_reg;
  logic bp_hit_reg;
  logic bp_hit_next;
  logic halt_meta_reg;
  logic halt_sync_reg;
  logic [1:0] quiet_reg;
  logic [1:0] quiet_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic start_reg;
  halt_state_e state_reg;
  halt_state_e state_next;

  wire logic setup_phase;
  wire logic wr_access;
  wire logic hit_ctrl;
  wire logic hit_size;
  wire logic hit_status;
  wire logic hit_trig;
  wire logic addr_ok;
  wire logic dma_idle;
  wire logic bus_idle;
  wire logic halt_want;
  wire logic push_hit;
  wire logic regw_hit;
  wire logic bp_clear;
  wire logic [31:0] status_word;

  //--------------------------------------------------------------------
  // APB decode
  //--------------------------------------------------------------------
  // Address decode and strobes
  assign hit_ctrl = (paddr == debug_halt_pkg::OFS_CTRL);
  assign hit_size = (paddr == debug_halt_pkg::OFS_SIZE);
  assign hit_status = (paddr == debug_halt_pkg::OFS_STATUS);
  assign hit_trig = (paddr == debug_halt_pkg::OFS_TRIG);
  assign addr_ok = hit_ctrl || hit_size || hit_status || hit_trig;
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite && addr_ok;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_reg;

  // Status word: block state visible to software
  assign status_word = {
    10'h000,
    bp_hit_reg,
    (state_reg == st_halted),
    (state_reg == st_pending),
    dma_idle,
    dma.bus_req,
    dma.busy,
    {(16 - SIZE_W){1'b0}},
    dma.count
  };

  // Read data captured in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_phase) begin
      prdata_next = debug_halt_pkg::RDATA_ZERO;
      if (!pwrite && hit_ctrl) begin
        prdata_next = {29'h0000_0000, ctrl_reg};
      end else if (!pwrite && hit_size) begin
        prdata_next = {{(32 - SIZE_W){1'b0}}, size_reg};
      end else if (!pwrite && hit_status) begin
        prdata_next = status_word;
      end else if (!pwrite && hit_trig) begin
        prdata_next = {30'h0000_0000, trig_reg};
      end
    end
  end

  // Control register next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_access && hit_ctrl) begin
      ctrl_next = pwdata[debug_halt_pkg::CTRL_BURST_BIT:debug_halt_pkg::CTRL_EN_BIT];
    end
  end

  //--------------------------------------------------------------------
  // Register file
  //--------------------------------------------------------------------
  // Software registers and start strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= debug_halt_pkg::CTRL_RESET;
      size_reg <= '0;
      trig_reg <= debug_halt_pkg::TRIG_RESET;
      start_reg <= 1'b0;
      prdata_reg <= debug_halt_pkg::RDATA_ZERO;
    end else begin
      ctrl_reg <= ctrl_next;
      start_reg <= wr_access && hit_ctrl && pwdata[debug_halt_pkg::CTRL_START_BIT];
      prdata_reg <= prdata_next;
      if (wr_access && hit_size) begin
        size_reg <= pwdata[SIZE_W-1:0];
      end
      if (wr_access && hit_trig) begin
        trig_reg <= pwdata[debug_halt_pkg::TRIG_REGW_BIT:debug_halt_pkg::TRIG_PUSH_BIT];
      end
    end
  end

  //--------------------------------------------------------------------
  // DMA channel
  //--------------------------------------------------------------------
  // Channel controls from the registers; halted device freezes it
  assign dma.enable = ctrl_reg[debug_halt_pkg::CTRL_EN_BIT];
  assign dma.repeat_mode = ctrl_reg[debug_halt_pkg::CTRL_REPEAT_BIT];
  assign dma.burst_mode = ctrl_reg[debug_halt_pkg::CTRL_BURST_BIT];
  assign dma.start = start_reg;
  assign dma.size = size_reg;
  assign dma.freeze = (state_reg == st_halted);
  assign dma_bus_req = dma.bus_req;
  assign dma_xfer = dma.xfer;

  dma_engine #(.SIZE_W(SIZE_W)) u_engine (
    .core_clk(core_clk),
    .rstn(rstn),
    .dma(dma)
  );

  //--------------------------------------------------------------------
  // Bus idle detection
  //--------------------------------------------------------------------
  // Count quiet cycles since the last DMA request, saturating
  always_comb begin
    quiet_next = quiet_reg;
    if (dma.bus_req) begin
      quiet_next = 2'h0;
    end else if (quiet_reg != debug_halt_pkg::IDLE_GAP) begin
      quiet_next = quiet_reg + 2'h1;
    end
  end

  assign dma_idle = (quiet_reg == debug_halt_pkg::IDLE_GAP) && !dma.bus_req;
  assign bus_idle = dma_idle && !cpu_bus_req;

  //--------------------------------------------------------------------
  // Breakpoint triggers
  //--------------------------------------------------------------------
  // Combined push trigger only fires for register or immediate pushes
  assign push_hit = trig_reg[debug_halt_pkg::TRIG_PUSH_BIT] && push_fetch && push_value_match &&
                    ((push_mode == debug_halt_pkg::am_register) ||
                     (push_mode == debug_halt_pkg::am_immediate));
  // Register-write trigger blind to repeated rotates
  assign regw_hit = trig_reg[debug_halt_pkg::TRIG_REGW_BIT] && regw_valid && regw_match &&
                    !debug_halt_pkg::is_rotate_multi(regw_op);
  assign bp_clear = wr_access && hit_status && pwdata[debug_halt_pkg::ST_BP_HIT_BIT];

  // Sticky breakpoint flag; a new hit beats a write-one clear
  always_comb begin
    bp_hit_next = bp_hit_reg;
    if (push_hit || regw_hit) begin
      bp_hit_next = 1'b1;
    end else if (bp_clear) begin
      bp_hit_next = 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Halt control
  //--------------------------------------------------------------------
  assign halt_want = halt_sync_reg || bp_hit_reg;

  // Halt request waits for an idle bus
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_run: begin
        if (halt_want && bus_idle) begin
          state_next = st_halted;
        end else if (halt_want) begin
          state_next = st_pending;
        end
      end
      st_pending: begin
        if (!halt_want) begin
          state_next = st_run;
        end else if (bus_idle) begin
          state_next = st_halted;
        end
      end
      st_halted: begin
        if (!halt_want) begin
          state_next = st_run;
        end
      end
      default: begin
        state_next = st_run;
      end
    endcase
  end

  assign halt_pending = (state_reg == st_pending);
  assign device_halt = (state_reg == st_halted);

  // Probe synchroniser, quiet counter, halt state, breakpoint flag
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      halt_meta_reg <= 1'b0;
      halt_sync_reg <= 1'b0;
      quiet_reg <= debug_halt_pkg::IDLE_GAP;
      state_reg <= st_run;
      bp_hit_reg <= 1'b0;
    end else begin
      halt_meta_reg <= halt_req_pin;
      halt_sync_reg <= halt_meta_reg;
      quiet_reg <= quiet_next;
      state_reg <= state_next;
      bp_hit_reg <= bp_hit_next;
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  sequence last_of_block;
    dma.xfer && (dma.count == SIZE_W'(1));
  endsequence

  sequence cpu_window;
    !dma.bus_req [*2];
  endsequence

  chk_repeat_reload: assert property (@(posedge core_clk) disable iff (!rstn)
    last_of_block ##0 (dma.repeat_mode && dma.enable && !dma.start) |=> dma.busy && (dma.count == $past(dma.size)))
    else $error("repeat mode did not reload the size counter");

  chk_single_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    last_of_block ##0 !(dma.repeat_mode && dma.enable) |=> !dma.busy)
    else $error("channel kept running after its last transfer");

  // Software may leave burst-block mode mid-run; the interleave only binds while it stays set
  chk_burst_cpu_gap: assert property (@(posedge core_clk) disable iff (!rstn || dma.freeze || !dma.burst_mode)
    ($fell(dma.bus_req) && dma.busy && dma.burst_mode && !dma.start) |-> cpu_window ##1 (dma.bus_req || !dma.busy))
    else $error("burst-block interleave did not give the CPU two cycles");

  // A cleared enable may end the block inside a DMA window
  chk_burst_dma_run: assert property (@(posedge core_clk) disable iff (!rstn || dma.freeze || !dma.enable)
    ($rose(dma.bus_req) && dma.burst_mode && dma.repeat_mode && dma.enable && !dma.start) |->
      dma.bus_req [*8] ##1 !dma.bus_req)
    else $error("burst-block interleave did not give the DMA eight cycles");

  chk_idle_late: assert property (@(posedge core_clk) disable iff (!rstn)
    dma.bus_req |-> !dma_idle [*4])
    else $error("bus counted idle too soon after a DMA request");

  chk_idle_reached: assert property (@(posedge core_clk) disable iff (!rstn)
    dma.bus_req ##1 !dma.bus_req [*4] |-> dma_idle)
    else $error("bus not idle after three quiet cycles");

  chk_grant_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(device_halt) |-> $past(dma_idle) && !$past(cpu_bus_req))
    else $error("halt granted while the bus was busy");

  chk_repeat_no_halt: assert property (@(posedge core_clk) disable iff (!rstn)
    ##1 ($past(dma.busy) && dma.busy && dma.repeat_mode && dma.burst_mode && dma.enable) |-> !$rose(device_halt))
    else $error("halt granted during repeat burst-block transfers");

  chk_pending_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (halt_pending && halt_want && !bus_idle) |=> halt_pending)
    else $error("pending halt request lost");

  chk_pending_grant: assert property (@(posedge core_clk) disable iff (!rstn)
    (halt_pending && halt_want && bus_idle) |=> device_halt)
    else $error("pending halt not granted on idle bus");

  chk_push_missed: assert property (@(posedge core_clk) disable iff (!rstn)
    (push_fetch && push_value_match && !bp_hit_reg && !regw_hit &&
     ((push_mode == debug_halt_pkg::am_indexed) || (push_mode == debug_halt_pkg::am_indirect))) |=> !bp_hit_reg)
    else $error("combined push trigger fired for a memory-mode push");

  chk_rotate_blind: assert property (@(posedge core_clk) disable iff (!rstn)
    (regw_valid && regw_match && debug_halt_pkg::is_rotate_multi(regw_op) && !bp_hit_reg && !push_hit) |=> !bp_hit_reg)
    else $error("register-write trigger fired on a repeated rotate");

endmodule // debug_halt_bus_gating

// ==== dv/debug_probe_model.sv ====
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Debug probe model driving the halt request pin
//----------------------------------------------------------------------
module debug_probe_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic halt_cmd,
  input wire logic dma_busy_hint,
  input wire logic careless,
  output logic halt_req_pin
);
  // Holds off halts while dma_busy_hint is set unless careless is set
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      halt_req_pin <= 1'b0;
    end else begin
      halt_req_pin <= halt_cmd && (careless || !dma_busy_hint);
    end
  end
endmodule // debug_probe_model

// ==== dv/debug_halt_bus_gating_tb.sv ====
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Self-checking bench for the debug halt and bus gating block
//----------------------------------------------------------------------
module debug_halt_bus_gating_tb;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic cpu_bus_req, halt_req_pin, push_fetch, push_value_match;
  logic [1:0] push_mode;
  logic regw_valid, regw_match, dma_bus_req, dma_xfer, halt_pending, device_halt;
  logic [2:0] regw_op;
  logic halt_cmd, hint, careless, err;
  int n_errors, compares;

  debug_halt_bus_gating debug_halt_bus_gating_inst (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_bus_req(cpu_bus_req), .halt_req_pin(halt_req_pin), .push_fetch(push_fetch),
    .push_mode(push_mode), .push_value_match(push_value_match), .regw_valid(regw_valid),
    .regw_op(regw_op), .regw_match(regw_match), .dma_bus_req(dma_bus_req), .dma_xfer(dma_xfer),
    .halt_pending(halt_pending), .device_halt(device_halt)
  );

  debug_probe_model debug_probe_model_inst (
    .core_clk(core_clk), .rstn(rstn), .halt_cmd(halt_cmd), .dma_busy_hint(hint),
    .careless(careless), .halt_req_pin(halt_req_pin)
  );

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Comparison and sampling helpers
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  // APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    check(n == 1, "apb wait states");
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, a, wd, x);
  endtask

  // Bounded waits on design outputs
  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (dma_bus_req !== v && n < 40) begin
      step;
      n++;
    end
    check(n < 40, "dma request wait");
  endtask

  task automatic wait_halt(input logic v);
    int n;
    n = 0;
    while (device_halt !== v && n < 20) begin
      step;
      n++;
    end
    check(n < 20, "halt wait");
  endtask

  // Reset values and unmapped access
  task automatic t_regs;
    apb(1'b0, debug_halt_pkg::OFS_CTRL, 32'h0000_0000, d);
    check(d === 32'h0000_0000, "ctrl reset");
    apb(1'b0, debug_halt_pkg::OFS_TRIG, 32'h0000_0000, d);
    check(d === 32'h0000_0000, "trig reset");
    apb(1'b0, debug_halt_pkg::OFS_STATUS, 32'h0000_0000, d);
    check(d === 32'h0004_0000, "status reset");
    apb(1'b0, 12'h010, 32'h0000_0000, d);
    check(err === 1'b1 && d === 32'h0000_0000, "unmapped read");
    $display("test regs done");
  endtask

  // Halt waits for the DMA to go quiet
  task automatic t_idle;
    int k;
    wr(debug_halt_pkg::OFS_SIZE, 32'h0000_0008);
    wr(debug_halt_pkg::OFS_CTRL, 32'h0000_0009);
    wait_req(1'b1);
    @(posedge core_clk);
    halt_cmd <= 1'b1;
    wait_req(1'b0);
    check(halt_pending === 1'b1 && device_halt === 1'b0, "halt not pending");
    k = 0;
    while (device_halt !== 1'b1 && k < 10) begin
      step;
      k++;
    end
    check(k == 4, "halt grant spacing");
    @(posedge core_clk);
    halt_cmd <= 1'b0;
    wait_halt(1'b0);
    $display("test idle done");
  endtask

  // Repeated block transfer keeps running until enable is cleared
  task automatic t_repeat;
    wr(debug_halt_pkg::OFS_SIZE, 32'h0000_0003);
    wr(debug_halt_pkg::OFS_CTRL, 32'h0000_000B);
    wait_req(1'b1);
    repeat (10) begin
      step;
      check(dma_bus_req === 1'b1 && dma_xfer === 1'b1, "repeat gap");
    end
    wr(debug_halt_pkg::OFS_CTRL, 32'h0000_0000);
    wait_req(1'b0);
    apb(1'b0, debug_halt_pkg::OFS_STATUS, 32'h0000_0000, d);
    check(d[16] === 1'b0 && dma_bus_req === 1'b0, "repeat not stopped");
    $display("test repeat done");
  endtask

  // Burst-block interleave, eight on and two off
  task automatic t_burst;
    wr(debug_halt_pkg::OFS_SIZE, 32'h0000_0010);
    wr(debug_halt_pkg::OFS_CTRL, 32'h0000_000D);
    wait_req(1'b1);
    for (int i = 0; i < 20; i++) begin
      check(dma_bus_req === ((i % 10) < 8), "burst slot");
      step;
    end
    check(dma_bus_req === 1'b0, "burst overrun");
    $display("test burst done");
  endtask

  // Repeat burst-block never lets a halt in; pending halt lands once free
  task automatic t_hold;
    wr(debug_halt_pkg::OFS_SIZE, 32'h0000_0004);
    wr(debug_halt_pkg::OFS_CTRL, 32'h0000_000F);
    wait_req(1'b1);
    // Halt asked only once traffic runs, else the idle bus grants it at once
    @(posedge core_clk);
    hint <= 1'b1;
    halt_cmd <= 1'b1;
    repeat (8) step;
    check(halt_pending === 1'b0 && device_halt === 1'b0, "probe did not hold off");
    @(posedge core_clk);
    careless <= 1'b1;
    repeat (40) begin
      step;
      check(device_halt === 1'b0, "halt during burst");
    end
    check(halt_pending === 1'b1, "halt dropped");
    @(posedge core_clk);
    cpu_bus_req <= 1'b1;
    wr(debug_halt_pkg::OFS_CTRL, 32'h0000_0000);
    wait_req(1'b0);
    repeat (8) step;
    check(device_halt === 1'b0 && halt_pending === 1'b1, "halt with cpu busy");
    @(posedge core_clk);
    cpu_bus_req <= 1'b0;
    step;
    check(device_halt === 1'b1, "late grant");
    @(posedge core_clk);
    halt_cmd <= 1'b0;
    careless <= 1'b0;
    hint <= 1'b0;
    wait_halt(1'b0);
    $display("test hold done");
  endtask

  // One trigger event, then expected halt and hit flag
  task automatic trig(input logic push, input int m, input logic exp);
    @(posedge core_clk);
    push_fetch <= push;
    push_value_match <= push;
    push_mode <= 2'(m);
    regw_valid <= !push;
    regw_match <= !push;
    regw_op <= 3'(m);
    @(posedge core_clk);
    push_fetch <= 1'b0;
    regw_valid <= 1'b0;
    repeat (3) step;
    check(device_halt === exp, "trigger halt");
    apb(1'b0, debug_halt_pkg::OFS_STATUS, 32'h0000_0000, d);
    check(d[21] === exp, "trigger flag");
    wr(debug_halt_pkg::OFS_STATUS, 32'h0020_0000);
    wait_halt(1'b0);
  endtask

  task automatic t_trig;
    wr(debug_halt_pkg::OFS_TRIG, 32'h0000_0003);
    for (int m = 0; m < 4; m++) trig(1'b1, m, m == 0 || m == 3);
    for (int m = 0; m < 5; m++) trig(1'b0, m, m == 0);
    wr(debug_halt_pkg::OFS_TRIG, 32'h0000_0000);
    trig(1'b1, 0, 1'b0);
    trig(1'b0, 0, 1'b0);
    $display("test triggers done");
  endtask

  // Verdict
  task automatic print_verdict;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(40 * 20000);
    n_errors++;
    $display("unexpected at %0t: watchdog", $time);
    print_verdict;
  end

  // Main sequence
  initial begin
    n_errors = 0;
    compares = 0;
    {rstn, psel, penable, pwrite, cpu_bus_req, push_fetch, push_value_match} = '0;
    {regw_valid, regw_match, halt_cmd, hint, careless} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    push_mode = 2'h0;
    regw_op = 3'h0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs;
    t_idle;
    t_repeat;
    t_burst;
    t_hold;
    t_trig;
    print_verdict;
  end
endmodule // debug_halt_bus_gating_tb
